// ===== dv/far_link.sv
`timescale 1ns/100ps

module far_link import link_pkg::*; (
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  rst,
	// wires
	input  wire logic  line_in,
	output logic       line_out,
	// bench control
	input  wire logic  slow_ack,
	input  wire logic  send_go,
	input  wire byte_t send_val,
	// observations
	output byte_t      got_byte,
	output byte_t      got_n,
	output byte_t      ack_n
);
	logic [3:0] ipos_r;
	logic [3:0] left_r;
	logic [9:0] bits_r;
	byte_t      sh_r;
	logic       ack_due_r;
	logic       pend_r;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ipos_r <= 4'h0;
			left_r <= 4'h0;
			bits_r <= 10'h000;
			sh_r <= 8'h00;
			ack_due_r <= 1'b0;
			pend_r <= 1'b0;
			line_out <= 1'b0;
			got_byte <= 8'h00;
			got_n <= 8'h00;
			ack_n <= 8'h00;
		end else begin
			if (ipos_r == 4'h0)
				ipos_r <= {3'h0, line_in};
			else if (ipos_r == 4'h1) begin
				ipos_r <= line_in ? 4'h2 : 4'h0;
				if (!line_in)
					ack_n <= ack_n + 8'h01;
				if (line_in && !slow_ack)
					ack_due_r <= 1'b1;
			end else if (ipos_r == 4'hA) begin
				ipos_r <= 4'h0;
				got_byte <= sh_r;
				got_n <= got_n + 8'h01;
				if (slow_ack)
					ack_due_r <= 1'b1;
			end else begin
				sh_r <= {line_in, sh_r[7:1]};
				ipos_r <= ipos_r + 4'h1;
			end
			if (send_go)
				pend_r <= 1'b1;
			// acks go ahead of waiting data
			if (left_r != 4'h0) begin
				line_out <= bits_r[0];
				bits_r <= bits_r >> 1;
				left_r <= left_r - 4'h1;
			end else if (ack_due_r) begin
				line_out <= 1'b1;
				bits_r <= 10'h000;
				left_r <= 4'h1;
				ack_due_r <= 1'b0;
			end else if (pend_r) begin
				line_out <= 1'b1;
				bits_r <= {1'b0, send_val, 1'b1};
				left_r <= 4'hA;
				pend_r <= 1'b0;
			end else
				line_out <= 1'b0;
		end
	end
endmodule : far_link

// ===== dv/link_properties.sv
`timescale 1ns/100ps

module link_properties import link_pkg::*; (
	// clock and reset
	input wire logic  mclk,
	input wire logic  rst,
	// instruction
	input wire logic  cmd_valid,
	input wire word_t cmd_chan,
	input wire logic  cmd_taken,
	input wire logic  cmd_done,
	input wire logic  desched,
	// list
	input wire word_t list_front,
	input wire word_t list_back,
	// memory
	input wire logic  mem_req,
	input wire logic  mem_we,
	input wire logic  mem_byte,
	input wire word_t mem_wdata,
	input wire logic  mem_ack,
	// wires
	input wire logic  link_in,
	input wire logic  link_out
);
	logic [3:0] opos_r;
	logic [3:0] ipos_r;
	logic       unacked_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// bit position within a packet on each wire
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			opos_r <= 4'h0;
		else if (opos_r == 4'h0)
			opos_r <= {3'h0, link_out};
		else if (opos_r == 4'h1)
			opos_r <= link_out ? 4'h2 : 4'h0;
		else
			opos_r <= (opos_r == 4'hA) ? 4'h0 : opos_r + 4'h1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ipos_r <= 4'h0;
		else if (ipos_r == 4'h0)
			ipos_r <= {3'h0, link_in};
		else if (ipos_r == 4'h1)
			ipos_r <= link_in ? 4'h2 : 4'h0;
		else
			ipos_r <= (ipos_r == 4'hA) ? 4'h0 : ipos_r + 4'h1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			unacked_r <= 1'b0;
		else if (opos_r == 4'h1 && link_out)
			unacked_r <= 1'b1;
		else if (ipos_r == 4'h1 && !link_in)
			unacked_r <= 1'b0;
	end

	sequence data_hdr_s;
		opos_r == 4'h1 && link_out;
	endsequence

	sequence chan_clr_s;
		mem_req && mem_ack && mem_we && !mem_byte && mem_wdata == 16'h8000;
	endsequence

	AST_STOP_LOW: assert property (opos_r == 4'hA |-> !link_out)
		else $error("data stop bit high");
	AST_ACK_FIRST: assert property (data_hdr_s |-> !unacked_r)
		else $error("byte sent before ack");
	AST_RESET_IDLE: assert property ($past(rst) |-> !link_out ##1 !link_out)
		else $error("wire busy after reset");
	AST_TAKEN_CAUSE: assert property (cmd_taken |-> $past(cmd_valid))
		else $error("taken without request");
	AST_LINK_DESCHED: assert property (cmd_taken && cmd_chan[15:2] == 14'h0 |-> desched)
		else $error("link command not descheduled");
	AST_SOFT_STAY: assert property (cmd_taken && cmd_chan[15:2] != 14'h0 |-> !desched)
		else $error("memory channel descheduled early");
	AST_CLEAR_DONE: assert property (chan_clr_s |-> ##[1:3] cmd_done)
		else $error("no done after channel clear");
	AST_FIRST_PARK: assert property (desched && !cmd_taken |-> $past(mem_we && mem_ack))
		else $error("park without workspace write");
	AST_TAIL_APPEND: assert property ($changed(list_back) && list_back != 16'h8000 &&
		$past(list_front) != 16'h8000 |-> $stable(list_front))
		else $error("append moved list front");
endmodule : link_properties

bind serial_channel_link link_properties link_properties_inst (.mclk(mclk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_chan(cmd_chan), .cmd_taken(cmd_taken), .cmd_done(cmd_done),
	.desched(desched), .list_front(list_front), .list_back(list_back), .mem_req(mem_req),
	.mem_we(mem_we), .mem_byte(mem_byte), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
	.link_in(link_in), .link_out(link_out));

// ===== dv/tb_serial_channel_link.sv
`timescale 1ns/100ps

module tb_serial_channel_link import link_pkg::*; ;
	logic  mclk, rst, cmd_valid, cmd_output, cmd_taken, cmd_done, desched, list_take;
	logic  list_lock, mem_req, mem_we, mem_byte, mem_ack, link_in, link_out, slow, send_go;
	word_t cmd_msg_ptr, cmd_chan, cmd_count, cmd_wptr, list_take_next, list_front, list_back;
	word_t mem_addr, mem_wdata, mem_rdata, watch;
	byte_t got_byte, got_n, ack_n, acks0;
	byte_t bmem [0:1023];
	int    fail_count, compares;

	serial_channel_link serial_channel_link_inst (.mclk(mclk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_output(cmd_output), .cmd_msg_ptr(cmd_msg_ptr),
		.cmd_chan(cmd_chan), .cmd_count(cmd_count), .cmd_wptr(cmd_wptr),
		.cmd_taken(cmd_taken), .cmd_done(cmd_done), .desched(desched),
		.list_take(list_take), .list_take_next(list_take_next), .list_front(list_front),
		.list_back(list_back), .list_lock(list_lock), .mem_req(mem_req), .mem_we(mem_we),
		.mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .link_in(link_in), .link_out(link_out));

	far_link far_link_inst (.mclk(mclk), .rst(rst), .line_in(link_out), .line_out(link_in),
		.slow_ack(slow), .send_go(send_go), .send_val(8'h96), .got_byte(got_byte),
		.got_n(got_n), .ack_n(ack_n));

	always #50 mclk = ~mclk;

	// byte memory, ack one cycle after request
	always @(negedge mclk) begin
		if (mem_req && !mem_ack) begin
			mem_ack <= 1'b1;
			if (mem_we) begin
				bmem[mem_addr[9:0]] <= mem_wdata[7:0];
				if (!mem_byte)
					bmem[mem_addr[9:0] + 10'h1] <= mem_wdata[15:8];
			end else
				mem_rdata <= {mem_byte ? 8'h00 : bmem[mem_addr[9:0] + 10'h1], bmem[mem_addr[9:0]]};
		end else
			mem_ack <= 1'b0;
	end

	function automatic word_t wd(input int a);
		return {bmem[a + 1], bmem[a]};
	endfunction : wd

	task automatic report_and_stop();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic check(input word_t seen, input word_t exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %0t saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic timed_out();
		fail_count++;
		$display("unexpected %0t wait ran out", $time);
		report_and_stop();
	endtask : timed_out

	task automatic issue(input logic o, input word_t msg, chan, cnt, wp);
		int n;
		@(negedge mclk);
		cmd_valid = 1'b1;
		cmd_output = o;
		cmd_msg_ptr = msg;
		cmd_chan = chan;
		cmd_count = cnt;
		cmd_wptr = wp;
		for (n = 0; n < 200; n++) begin
			@(negedge mclk);
			if (cmd_taken === 1'b1)
				break;
		end
		if (n == 200)
			timed_out();
		check({15'h0, desched}, {15'h0, chan[15:2] == 14'h0});
		cmd_valid = 1'b0;
	endtask : issue

	// 0 desched, 1 done, 2 list tail equals watch
	task automatic await(input int which);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(negedge mclk);
			if ((which == 0 && desched === 1'b1) || (which == 1 && cmd_done === 1'b1) ||
				(which == 2 && list_back === watch))
				break;
		end
		if (n == 3000)
			timed_out();
	endtask : await

	task automatic t_soft_first();
		bmem[256] = 8'h00;
		bmem[257] = 8'h80;
		issue(1'b1, 16'h0200, 16'h0100, 16'h0002, 16'h0300);
		await(0);
		check(wd(256), 16'h0300);
		check(wd(764), 16'h0200);
		check(list_front, 16'h8000);
	endtask : t_soft_first

	task automatic t_soft_second();
		bmem[512] = 8'hAA;
		bmem[513] = 8'h55;
		watch = 16'h0300;
		issue(1'b0, 16'h0280, 16'h0100, 16'h0002, 16'h0340);
		await(1);
		await(2);
		check(wd(640), 16'h55AA);
		check(wd(256), 16'h8000);
		check(list_front, 16'h0300);
	endtask : t_soft_second

	task automatic t_link_out(input logic s, input word_t wp, prev, input byte_t n);
		slow = s;
		bmem[928] = 8'h3C;
		bmem[929] = 8'hC3;
		watch = wp;
		issue(1'b1, 16'h03A0, 16'h0000, 16'h0002, wp);
		await(2);
		check({15'h0, list_lock}, 16'h0001);
		check(list_back, wp);
		// with slow off, the overlapped ack lets the append finish before the last stop bit
		repeat (4) @(negedge mclk);
		check({8'h00, got_n}, {8'h00, n});
		check({8'h00, got_byte}, 16'h00C3);
		check(wd(int'(prev) - 2), wp);
		check(list_front, 16'h0300);
	endtask : t_link_out

	task automatic t_link_in();
		acks0 = ack_n;
		@(negedge mclk);
		send_go = 1'b1;
		@(negedge mclk);
		send_go = 1'b0;
		repeat (40) @(negedge mclk);
		check({8'h00, ack_n}, {8'h00, acks0});
		watch = 16'h03C0;
		issue(1'b0, 16'h03F0, 16'h0001, 16'h0001, 16'h03C0);
		await(2);
		repeat (4) @(negedge mclk);
		check({8'h00, bmem[1008]}, 16'h0096);
		check({8'h00, ack_n}, {8'h00, acks0 + 8'h01});
		// engine set up before the data arrives
		watch = 16'h03D0;
		issue(1'b0, 16'h03F1, 16'h0001, 16'h0001, 16'h03D0);
		send_go = 1'b1;
		@(negedge mclk);
		send_go = 1'b0;
		await(2);
		repeat (4) @(negedge mclk);
		check({8'h00, bmem[1009]}, 16'h0096);
		check({8'h00, ack_n}, {8'h00, acks0 + 8'h02});
	endtask : t_link_in

	task automatic t_list_take();
		check({15'h0, list_lock}, 16'h0000);
		list_take_next = 16'h0380;
		list_take = 1'b1;
		@(negedge mclk);
		check(list_front, 16'h0380);
		check(list_back, 16'h03D0);
		list_take_next = 16'h8000;
		@(negedge mclk);
		list_take = 1'b0;
		check(list_front, 16'h8000);
		check(list_back, 16'h8000);
	endtask : t_list_take

	// input arrives first, output second
	task automatic t_soft_reverse();
		bmem[260] = 8'h00;
		bmem[261] = 8'h80;
		bmem[352] = 8'h5A;
		issue(1'b0, 16'h0120, 16'h0104, 16'h0001, 16'h0140);
		await(0);
		check(wd(260), 16'h0140);
		check(wd(316), 16'h0120);
		watch = 16'h0140;
		issue(1'b1, 16'h0160, 16'h0104, 16'h0001, 16'h0180);
		await(1);
		await(2);
		check({8'h00, bmem[288]}, 16'h005A);
		check(wd(260), 16'h8000);
		check(list_front, 16'h0140);
	endtask : t_soft_reverse

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_output = 1'b0;
		cmd_msg_ptr = 16'h0000;
		cmd_chan = 16'h0000;
		cmd_count = 16'h0000;
		cmd_wptr = 16'h0000;
		list_take = 1'b0;
		list_take_next = 16'h8000;
		mem_rdata = 16'h0000;
		mem_ack = 1'b0;
		slow = 1'b0;
		send_go = 1'b0;
		watch = 16'h0000;
		fail_count = 0;
		compares = 0;
		for (int i = 0; i < 1024; i++)
			bmem[i] = 8'h00;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		check(list_front, 16'h8000);
		check(list_back, 16'h8000);
		check({15'h0, link_out}, 16'h0000);
		t_soft_first();
		t_soft_second();
		t_link_out(1'b0, 16'h0380, 16'h0300, 8'h02);
		t_link_out(1'b1, 16'h0390, 16'h0380, 8'h04);
		t_link_in();
		t_list_take();
		t_soft_reverse();
		report_and_stop();
	end
endmodule : tb_serial_channel_link

// ===== logic/link_defines.svh
`ifndef LINK_DEFINES_SVH
`define LINK_DEFINES_SVH

// word and address width
`define WORD_W 16
// channel word value meaning no waiting process
`define EMPTY_CHAN 16'h8000
// channel addresses with these bits all clear are the hard link channels
`define LINK_CHAN_MASK 16'hFFFC
// workspace slot below the workspace pointer holding the message pointer
`define WS_MSG_OFS 16'h0004
// workspace slot below the workspace pointer holding the list link
`define WS_NEXT_OFS 16'h0002
// serial packet receive bit positions and transmit bits left, one bit per clock
`define RX_HDR_POS 4'h1
`define RX_STOP_POS 4'hA
`define TX_ACK_LEFT 4'h1
`define TX_DATA_LEFT 4'hA

`endif

// ===== logic/link_pkg.sv
`include "link_defines.svh"

package link_pkg;

	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [7:0]         byte_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CH_RD,
		ST_CH_WID,
		ST_WS_WR,
		ST_WS_RD,
		ST_CP_RD,
		ST_CP_WR,
		ST_CH_CLR,
		ST_Q_APPEND,
		ST_TX_FETCH,
		ST_RX_STORE
	} state_t;

endpackage : link_pkg

// ===== logic/link_rx.sv
`timescale 1ns/100ps
`include "link_defines.svh"

module link_rx import link_pkg::*; (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// serial wire
	input  wire logic line,
	// received events
	ser_if.rx         s
);
	logic [3:0] pos_r;
	byte_t      sh_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pos_r     <= 4'h0;
			sh_r      <= 8'h00;
			s.rx_hdr  <= 1'b0;
			s.rx_ack  <= 1'b0;
			s.rx_valid <= 1'b0;
			s.rx_byte <= 8'h00;
		end else begin
			s.rx_hdr   <= 1'b0;
			s.rx_ack   <= 1'b0;
			s.rx_valid <= 1'b0;
			if (pos_r == 4'h0) begin
				if (line) begin
					pos_r <= `RX_HDR_POS; // R19
				end
			end else if (pos_r == `RX_HDR_POS) begin
				// second bit tells data from acknowledge
				if (line) begin
					s.rx_hdr <= 1'b1; // R16
					pos_r    <= pos_r + 4'h1;
				end else begin
					s.rx_ack <= 1'b1; // R13
					pos_r    <= 4'h0;
				end
			end else if (pos_r == `RX_STOP_POS) begin
				s.rx_valid <= 1'b1; // R12
				s.rx_byte  <= sh_r;
				pos_r      <= 4'h0;
			end else begin
				sh_r  <= {line, sh_r[7:1]};
				pos_r <= pos_r + 4'h1;
			end
		end
	end

endmodule : link_rx

// ===== logic/link_tx.sv
`timescale 1ns/100ps
`include "link_defines.svh"

module link_tx import link_pkg::*; (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// packet requests
	ser_if.tx         s,
	// serial wire
	output logic      line
);
	logic [10:0] sh_r;
	logic [3:0]  left_r;
	logic        pend_ack_r;
	logic        pend_data_r;
	byte_t       pend_byte_r;

	assign s.tx_data_free = !pend_data_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			line        <= 1'b0; // R19
			sh_r        <= 11'h000;
			left_r      <= 4'h0;
			pend_ack_r  <= 1'b0;
			pend_data_r <= 1'b0;
			pend_byte_r <= 8'h00;
		end else begin
			if (left_r != 4'h0) begin
				line   <= sh_r[0];
				sh_r   <= {1'b0, sh_r[10:1]};
				left_r <= left_r - 4'h1;
			end else if (pend_ack_r) begin
				// acks go first so they overlap inbound data
				line       <= 1'b1; // R19
				sh_r       <= 11'h000; // R13
				left_r     <= `TX_ACK_LEFT;
				pend_ack_r <= 1'b0;
			end else if (pend_data_r) begin
				line        <= 1'b1;
				sh_r        <= {2'b00, pend_byte_r, 1'b1}; // R12
				left_r      <= `TX_DATA_LEFT;
				pend_data_r <= 1'b0; // R17
			end
			if (s.send_ack) begin
				pend_ack_r <= 1'b1;
			end
			if (s.send_data) begin
				pend_data_r <= 1'b1;
				pend_byte_r <= s.tx_byte;
			end
		end
	end

endmodule : link_tx

// ===== logic/ser_if.sv
`timescale 1ns/100ps

interface ser_if;
	logic       send_data;
	logic       send_ack;
	logic [7:0] tx_byte;
	logic       tx_data_free;
	logic       rx_hdr;
	logic       rx_ack;
	logic       rx_valid;
	logic [7:0] rx_byte;

	modport tx (
		input  send_data,
		input  send_ack,
		input  tx_byte,
		output tx_data_free
	);

	modport rx (
		output rx_hdr,
		output rx_ack,
		output rx_valid,
		output rx_byte
	);

	modport ctl (
		output send_data,
		output send_ack,
		output tx_byte,
		input  tx_data_free,
		input  rx_hdr,
		input  rx_ack,
		input  rx_valid,
		input  rx_byte
	);
endinterface : ser_if

// ===== logic/serial_channel_link.sv
// Overview of operation
// [R1] take pointer, channel, count from instruction
// [R2] channel address alone selects internal or link
// [R3] channel word holds process or empty value
// [R4] first party stored in channel, descheduled
// [R5] first party saves message pointer in workspace
// [R6] second party copies, requeues partner, empties channel
// [R7] link transfer runs autonomously, process descheduled
// [R8] link engine holds workspace, pointer, count
// [R9] finished link transfer requeues waiting process
// [R10] either end may set up first
// [R11] one output wire, one input wire
// [R12] data: start, one, eight bits, stop
// [R13] ack: start then stop
// [R14] next byte only after previous ack
// [R15] ack only when accepted and buffer room
// [R16] ack may go on data header
// [R17] early ack lets next packet follow directly
// [R18] overlapped acks give full link rate
// [R19] wire idles low, start high, stop low
// [R20] resumed process appended at list tail
`timescale 1ns/100ps
`include "link_defines.svh"

module serial_channel_link import link_pkg::*; (
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  rst,
	// message instruction
	input  wire logic  cmd_valid,
	input  wire logic  cmd_output,
	input  wire word_t cmd_msg_ptr,
	input  wire word_t cmd_chan,
	input  wire word_t cmd_count,
	input  wire word_t cmd_wptr,
	output logic       cmd_taken,
	output logic       cmd_done,
	output logic       desched,
	// scheduling list
	input  wire logic  list_take,
	input  wire word_t list_take_next,
	output word_t      list_front,
	output word_t      list_back,
	output logic       list_lock,
	// memory
	output logic       mem_req,
	output logic       mem_we,
	output logic       mem_byte,
	output word_t      mem_addr,
	output word_t      mem_wdata,
	input  wire word_t mem_rdata,
	input  wire logic  mem_ack,
	// link wires
	input  wire logic  link_in,
	output logic       link_out
);
	ser_if sif ();

	state_t st_r;
	logic   out_r;
	word_t  mptr_r;
	word_t  chan_r;
	word_t  cnt_r;
	word_t  wptr_r;
	word_t  pwptr_r;
	word_t  pmptr_r;
	word_t  idx_r;
	byte_t  byte_r;
	word_t  q_wptr_r;

	logic   lo_busy_r;
	word_t  lo_wptr_r;
	word_t  lo_mptr_r;
	word_t  lo_cnt_r;
	logic   lo_ackd_r;
	logic   li_busy_r;
	word_t  li_wptr_r;
	word_t  li_mptr_r;
	word_t  li_cnt_r;
	logic   buf_full_r;
	byte_t  buf_r;
	logic   ack_owed_r;
	logic   tx_send_r;
	logic   tx_ack_r;
	byte_t  tx_byte_r;

	logic   lo_fin;
	logic   li_fin;
	logic   need_store;
	logic   need_fetch;
	logic   ext_cmd;
	logic   lo_setup;
	logic   li_setup;
	logic   fetch_done;
	logic   store_done;
	logic   q_direct;
	logic   q_done;

	function automatic logic is_link(input word_t addr);
		is_link = ((addr & `LINK_CHAN_MASK) == 16'h0000);
	endfunction : is_link

	assign sif.send_data = tx_send_r;
	assign sif.send_ack  = tx_ack_r;
	assign sif.tx_byte   = tx_byte_r;

	// R11
	link_tx u_tx (
		.mclk (mclk),
		.rst  (rst),
		.s    (sif),
		.line (link_out)
	);

	link_rx u_rx (
		.mclk (mclk),
		.rst  (rst),
		.line (link_in),
		.s    (sif)
	);

	always_comb begin
		lo_fin     = lo_busy_r && (lo_cnt_r == 16'h0000) && lo_ackd_r; // R9
		li_fin     = li_busy_r && (li_cnt_r == 16'h0000); // R9
		need_store = li_busy_r && (li_cnt_r != 16'h0000) && buf_full_r;
		need_fetch = lo_busy_r && (lo_cnt_r != 16'h0000) && lo_ackd_r && sif.tx_data_free; // R14
		ext_cmd    = is_link(cmd_chan); // R2
		lo_setup   = (st_r == ST_IDLE) && !lo_fin && !li_fin && !need_store && !need_fetch
			&& cmd_valid && ext_cmd && cmd_output && !lo_busy_r;
		li_setup   = (st_r == ST_IDLE) && !lo_fin && !li_fin && !need_store && !need_fetch
			&& cmd_valid && ext_cmd && !cmd_output && !li_busy_r;
		fetch_done = (st_r == ST_TX_FETCH) && mem_ack;
		store_done = (st_r == ST_RX_STORE) && mem_ack;
		q_direct   = (st_r == ST_Q_APPEND) && !mem_req && (list_front == `EMPTY_CHAN);
		q_done     = (st_r == ST_Q_APPEND) && mem_req && mem_ack;
	end

	task automatic issue(input logic we, input logic bt, input word_t a, input word_t d);
		mem_req   <= 1'b1;
		mem_we    <= we;
		mem_byte  <= bt;
		mem_addr  <= a;
		mem_wdata <= d;
	endtask : issue

	// instruction and memory sequencing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r      <= ST_IDLE;
			out_r     <= 1'b0;
			mptr_r    <= 16'h0000;
			chan_r    <= 16'h0000;
			cnt_r     <= 16'h0000;
			wptr_r    <= 16'h0000;
			pwptr_r   <= 16'h0000;
			pmptr_r   <= 16'h0000;
			idx_r     <= 16'h0000;
			byte_r    <= 8'h00;
			q_wptr_r  <= 16'h0000;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_byte  <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
			cmd_taken <= 1'b0;
			cmd_done  <= 1'b0;
			desched   <= 1'b0;
		end else begin
			cmd_taken <= 1'b0;
			cmd_done  <= 1'b0;
			desched   <= 1'b0;
			if (mem_ack) begin
				mem_req <= 1'b0;
			end
			case (st_r)
				ST_IDLE: begin
					if (lo_fin) begin
						q_wptr_r <= lo_wptr_r;
						st_r     <= ST_Q_APPEND;
					end else if (li_fin) begin
						q_wptr_r <= li_wptr_r;
						st_r     <= ST_Q_APPEND;
					end else if (need_store) begin
						issue(1'b1, 1'b1, li_mptr_r, {8'h00, buf_r});
						st_r <= ST_RX_STORE;
					end else if (need_fetch) begin
						issue(1'b0, 1'b1, lo_mptr_r, 16'h0000);
						st_r <= ST_TX_FETCH;
					end else if (lo_setup || li_setup) begin
						cmd_taken <= 1'b1; // R7
						desched   <= 1'b1; // R7
					end else if (cmd_valid && !ext_cmd) begin
						out_r     <= cmd_output; // R1
						mptr_r    <= cmd_msg_ptr;
						chan_r    <= cmd_chan;
						cnt_r     <= cmd_count;
						wptr_r    <= cmd_wptr;
						idx_r     <= 16'h0000;
						cmd_taken <= 1'b1;
						issue(1'b0, 1'b0, cmd_chan, 16'h0000);
						st_r <= ST_CH_RD;
					end
				end
				ST_CH_RD: begin
					if (mem_ack) begin
						if (mem_rdata == `EMPTY_CHAN) begin
							issue(1'b1, 1'b0, chan_r, wptr_r); // R4
							st_r <= ST_CH_WID;
						end else begin
							pwptr_r <= mem_rdata;
							issue(1'b0, 1'b0, mem_rdata - `WS_MSG_OFS, 16'h0000);
							st_r <= ST_WS_RD;
						end
					end
				end
				ST_CH_WID: begin
					if (mem_ack) begin
						issue(1'b1, 1'b0, wptr_r - `WS_MSG_OFS, mptr_r); // R5
						st_r <= ST_WS_WR;
					end
				end
				ST_WS_WR: begin
					if (mem_ack) begin
						desched <= 1'b1; // R4
						st_r    <= ST_IDLE;
					end
				end
				ST_WS_RD: begin
					if (mem_ack) begin
						pmptr_r <= mem_rdata;
						if (cnt_r == 16'h0000) begin
							issue(1'b1, 1'b0, chan_r, `EMPTY_CHAN);
							st_r <= ST_CH_CLR;
						end else begin
							// R6
							issue(1'b0, 1'b1, (out_r ? mptr_r : mem_rdata), 16'h0000);
							st_r <= ST_CP_RD;
						end
					end
				end
				ST_CP_RD: begin
					if (mem_ack) begin
						byte_r <= mem_rdata[7:0];
						issue(1'b1, 1'b1, (out_r ? pmptr_r : mptr_r) + idx_r,
							{8'h00, mem_rdata[7:0]}); // R6
						st_r <= ST_CP_WR;
					end
				end
				ST_CP_WR: begin
					if (mem_ack) begin
						idx_r <= idx_r + 16'h0001;
						if (idx_r + 16'h0001 == cnt_r) begin
							issue(1'b1, 1'b0, chan_r, `EMPTY_CHAN); // R3
							st_r <= ST_CH_CLR;
						end else begin
							issue(1'b0, 1'b1, (out_r ? mptr_r : pmptr_r) + idx_r + 16'h0001,
								16'h0000);
							st_r <= ST_CP_RD;
						end
					end
				end
				ST_CH_CLR: begin
					if (mem_ack) begin
						q_wptr_r <= pwptr_r; // R6
						cmd_done <= 1'b1;
						st_r     <= ST_Q_APPEND;
					end
				end
				ST_Q_APPEND: begin
					if (q_direct) begin
						st_r <= ST_IDLE;
					end else if (!mem_req) begin
						issue(1'b1, 1'b0, list_back - `WS_NEXT_OFS, q_wptr_r); // R20
					end else if (mem_ack) begin
						st_r <= ST_IDLE;
					end
				end
				ST_TX_FETCH: begin
					if (mem_ack) begin
						st_r <= ST_IDLE;
					end
				end
				ST_RX_STORE: begin
					if (mem_ack) begin
						st_r <= ST_IDLE;
					end
				end
				default: begin
					st_r    <= ST_IDLE;
					mem_req <= 1'b0;
				end
			endcase
		end
	end

	// scheduling list front and back
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			list_front <= `EMPTY_CHAN;
			list_back  <= `EMPTY_CHAN;
			list_lock  <= 1'b0;
		end else begin
			list_lock <= (st_r == ST_Q_APPEND) || (lo_fin || li_fin);
			if (q_direct) begin
				list_front <= q_wptr_r; // R20
				list_back  <= q_wptr_r;
			end else if (q_done) begin
				list_back <= q_wptr_r; // R20
			end else if (list_take && !list_lock) begin
				list_front <= list_take_next;
				if (list_take_next == `EMPTY_CHAN) begin
					list_back <= `EMPTY_CHAN;
				end
			end
		end
	end

	// outbound link engine
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lo_busy_r <= 1'b0;
			lo_wptr_r <= 16'h0000;
			lo_mptr_r <= 16'h0000;
			lo_cnt_r  <= 16'h0000;
			lo_ackd_r <= 1'b0;
			tx_send_r <= 1'b0;
			tx_byte_r <= 8'h00;
		end else begin
			tx_send_r <= 1'b0;
			if (lo_setup) begin
				lo_busy_r <= 1'b1; // R8
				lo_wptr_r <= cmd_wptr;
				lo_mptr_r <= cmd_msg_ptr;
				lo_cnt_r  <= cmd_count;
				lo_ackd_r <= 1'b1;
			end else if (lo_fin && st_r == ST_IDLE) begin
				lo_busy_r <= 1'b0; // R9
			end
			if (fetch_done) begin
				tx_send_r <= 1'b1; // R17
				tx_byte_r <= mem_rdata[7:0];
				lo_mptr_r <= lo_mptr_r + 16'h0001;
				lo_cnt_r  <= lo_cnt_r - 16'h0001;
				lo_ackd_r <= 1'b0; // R14
			end
			if (sif.rx_ack && lo_busy_r) begin
				lo_ackd_r <= 1'b1; // R18
			end
		end
	end

	// inbound link engine and acknowledge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			li_busy_r  <= 1'b0;
			li_wptr_r  <= 16'h0000;
			li_mptr_r  <= 16'h0000;
			li_cnt_r   <= 16'h0000;
			buf_full_r <= 1'b0;
			buf_r      <= 8'h00;
			ack_owed_r <= 1'b0;
			tx_ack_r   <= 1'b0;
		end else begin
			tx_ack_r <= 1'b0;
			if (li_setup) begin
				li_busy_r <= 1'b1; // R8
				li_wptr_r <= cmd_wptr;
				li_mptr_r <= cmd_msg_ptr;
				li_cnt_r  <= cmd_count;
			end else if (li_fin && !lo_fin && st_r == ST_IDLE) begin
				li_busy_r <= 1'b0; // R9
			end
			if (store_done) begin
				buf_full_r <= 1'b0;
				li_mptr_r  <= li_mptr_r + 16'h0001;
				li_cnt_r   <= li_cnt_r - 16'h0001;
			end
			if (sif.rx_valid) begin
				buf_full_r <= 1'b1; // R10
				buf_r      <= sif.rx_byte;
			end
			if (sif.rx_hdr) begin
				if (li_busy_r && !buf_full_r) begin
					tx_ack_r <= 1'b1; // R16
				end else begin
					ack_owed_r <= 1'b1; // R15
				end
			end else if (ack_owed_r && li_busy_r && !buf_full_r) begin
				tx_ack_r   <= 1'b1; // R15
				ack_owed_r <= 1'b0;
			end
		end
	end

endmodule : serial_channel_link
